// file: hdl/readout_serial_port.sv
// Purpose: readout serial port with register access over AXI4-Lite
// Assumes: persistent store outside; it presents the saved cfg word
// Notes:   cfg writes are pushed to the store with a one-cycle strobe
`timescale 1ns/10ps
module readout_serial_port #(
  parameter int CLK_HZ = 50000000 // clock rate for bit timing
) (
  input  wire logic                           aclk,          // clock
  input  wire logic                           aresetn,       // sync reset, low
  input  wire logic [7:0]                     s_axi_awaddr,  // write address
  input  wire logic                           s_axi_awvalid, // write address valid
  output logic                                s_axi_awready, // write address ready
  input  wire logic [31:0]                    s_axi_wdata,   // write data
  input  wire logic [3:0]                     s_axi_wstrb,   // byte strobes
  input  wire logic                           s_axi_wvalid,  // write data valid
  output logic                                s_axi_wready,  // write data ready
  output logic [1:0]                          s_axi_bresp,   // write response
  output logic                                s_axi_bvalid,  // write response valid
  input  wire logic                           s_axi_bready,  // write response ready
  input  wire logic [7:0]                     s_axi_araddr,  // read address
  input  wire logic                           s_axi_arvalid, // read address valid
  output logic                                s_axi_arready, // read address ready
  output logic [31:0]                         s_axi_rdata,   // read data
  output logic [1:0]                          s_axi_rresp,   // read response
  output logic                                s_axi_rvalid,  // read data valid
  input  wire logic                           s_axi_rready,  // read data ready
  input  wire logic                           rxd,           // serial in pin
  output logic                                txd,           // serial out pin
  input  wire logic [serial_pkg::CFG_W-1:0]   nv_cfg_in,     // saved settings
  output logic [serial_pkg::CFG_W-1:0]        nv_cfg_out,    // settings to save
  output logic                                nv_store,      // save strobe
  output logic                                pos_req        // ctrl-b seen, pulse
);
  // ---------- settings ----------
  logic [serial_pkg::CFG_W-1:0] cfg_reg, cfg_next;
  logic                         boot_reg, boot_next;
  logic [serial_pkg::CFG_W-1:0] nvo_reg, nvo_next;
  logic                         nvs_reg, nvs_next;
  logic [serial_pkg::DIV_W-1:0] div_reg, div_next;
  logic [1:0]                   par_mode;
  logic                         data8;
  logic                         stop2;
  logic                         lf_en;
  logic [3:0]                   tail_cfg;

  assign par_mode = cfg_reg[serial_pkg::F_PAR_HI:serial_pkg::F_PAR_LO];
  assign data8    = cfg_reg[serial_pkg::F_DATA8];
  assign stop2    = cfg_reg[serial_pkg::F_STOP2];
  assign lf_en    = cfg_reg[serial_pkg::F_LF];
  assign tail_cfg = cfg_reg[serial_pkg::F_TAIL_HI:serial_pkg::F_TAIL_LO];

  // ---------- bus state ----------
  logic       aw_got_reg, aw_got_next;
  logic       w_got_reg, w_got_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic       awr_reg, awr_next;
  logic       wr_reg, wr_next;
  logic       bv_reg, bv_next;
  logic [1:0] br_reg, br_next;
  logic       arr_reg, arr_next;
  logic       rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic       do_wr;
  logic       do_rd;

  // ---------- stream state ----------
  logic [7:0] cur_reg, cur_next;
  logic       cur_v_reg, cur_v_next;
  logic [3:0] tail_reg, tail_next;
  logic [7:0] rxb_reg, rxb_next;
  logic [serial_pkg::ST_W-1:0] st_reg, st_next;
  logic       preq_reg, preq_next;
  logic       tx_ready;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       rx_perr;
  logic       rx_ferr;

  function automatic logic mapped(input logic [7:0] a);
    return a == serial_pkg::OFS_CFG || a == serial_pkg::OFS_STATUS ||
           a == serial_pkg::OFS_TXDATA || a == serial_pkg::OFS_RXDATA ||
           a == serial_pkg::OFS_CMD;
  endfunction

  assign do_wr = aw_got_reg && w_got_reg && !bv_reg;
  assign do_rd = s_axi_arvalid && arr_reg;

  always_comb begin
    aw_got_next = aw_got_reg;
    w_got_next  = w_got_reg;
    waddr_next  = waddr_reg;
    wdata_next  = wdata_reg;
    wstrb_next  = wstrb_reg;
    bv_next     = bv_reg;
    br_next     = br_reg;
    if (s_axi_awvalid && awr_reg) begin
      aw_got_next = 1'b1;
      waddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_reg) begin
      w_got_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bv_next     = 1'b1;
      br_next     = mapped(waddr_reg) ? serial_pkg::RESP_OKAY : serial_pkg::RESP_DECERR;
    end
    if (bv_reg && s_axi_bready) bv_next = 1'b0;
    awr_next = !aw_got_next && !bv_next;
    wr_next  = !w_got_next && !bv_next;
    arr_next = arr_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    if (do_rd) begin
      arr_next = 1'b0;
      rv_next  = 1'b1;
      rr_next  = mapped(s_axi_araddr) ? serial_pkg::RESP_OKAY : serial_pkg::RESP_DECERR;
      unique case (s_axi_araddr)
        serial_pkg::OFS_CFG:    rd_next = 32'(cfg_reg);
        serial_pkg::OFS_STATUS: rd_next = 32'(st_reg);
        serial_pkg::OFS_RXDATA: rd_next = 32'(rxb_reg);
        default:                rd_next = 32'h0000_0000;
      endcase
    end
    if (rv_reg && s_axi_rready) begin
      rv_next  = 1'b0;
      arr_next = 1'b1;
    end
    if (boot_reg) arr_next = 1'b1;
  end

  // settings: strap-like load from the store one cycle after reset release
  always_comb begin
    boot_next = 1'b0;
    cfg_next  = cfg_reg;
    nvs_next  = 1'b0;
    nvo_next  = nvo_reg;
    if (boot_reg) begin
      cfg_next = nv_cfg_in;
      nvo_next = nv_cfg_in;
    end else if (do_wr && waddr_reg == serial_pkg::OFS_CFG) begin
      if (wstrb_reg[0]) begin
        if (wdata_reg[3:0] < serial_pkg::BAUD_CODES)
          cfg_next[3:0] = wdata_reg[3:0];
        if (wdata_reg[5:4] != 2'h3)
          cfg_next[5:4] = wdata_reg[5:4];
        cfg_next[7:6] = wdata_reg[7:6];
      end
      if (wstrb_reg[1]) begin
        cfg_next[8] = wdata_reg[8];
        if (wdata_reg[12:9] < 4'd10)
          cfg_next[12:9] = wdata_reg[12:9];
      end
      nvs_next = 1'b1;
      nvo_next = cfg_next;
    end
    div_next = serial_pkg::bit_div(cfg_reg[serial_pkg::F_BAUD_HI:serial_pkg::F_BAUD_LO],
                                   CLK_HZ);
  end

  // outgoing stream: one held byte, lf after cr, tail of crs
  always_comb begin
    cur_next   = cur_reg;
    cur_v_next = cur_v_reg;
    tail_next  = tail_reg;
    if (cur_v_reg && tx_ready) begin
      if (cur_reg == serial_pkg::CH_CR && lf_en) cur_next = serial_pkg::CH_LF;
      else cur_v_next = 1'b0;
    end
    if (!cur_v_next && tail_reg != 4'd0) begin
      cur_next   = serial_pkg::CH_CR;
      cur_v_next = 1'b1;
      tail_next  = tail_reg - 4'd1;
    end else if (!cur_v_reg && tail_reg == 4'd0 && do_wr && wstrb_reg[0]) begin
      // export starts only on a local write
      if (waddr_reg == serial_pkg::OFS_TXDATA) begin
        cur_next   = wdata_reg[7:0];
        cur_v_next = 1'b1;
      end else if (waddr_reg == serial_pkg::OFS_CMD && wdata_reg[serial_pkg::CMD_TAIL])
        tail_next = tail_cfg;
    end
  end

  // status: sticky flags except the live tx busy bit, set wins over write-one-to-clear
  always_comb begin
    logic [serial_pkg::ST_W-1:0] clr;
    logic                        rd_rx;
    clr   = (do_wr && wstrb_reg[0] && waddr_reg == serial_pkg::OFS_STATUS) ?
            wdata_reg[serial_pkg::ST_W-1:0] : '0;
    rd_rx = do_rd && s_axi_araddr == serial_pkg::OFS_RXDATA;
    st_next = st_reg & ~clr;
    // held byte counts too, so no idle gap shows during a handover
    st_next[serial_pkg::ST_TX_BUSY] = cur_v_reg || cur_v_next || tail_next != 4'd0 || !tx_ready;
    if (rd_rx) st_next[serial_pkg::ST_RX_FULL] = 1'b0;
    rxb_next  = rxb_reg;
    preq_next = 1'b0;
    if (rx_valid) begin
      rxb_next = rx_byte;
      if (st_reg[serial_pkg::ST_RX_FULL] && !rd_rx) st_next[serial_pkg::ST_OVERRUN] = 1'b1;
      st_next[serial_pkg::ST_RX_FULL] = 1'b1;
      if (rx_perr) st_next[serial_pkg::ST_PAR_ERR] = 1'b1;
      if (rx_ferr) st_next[serial_pkg::ST_FRM_ERR] = 1'b1;
      if (rx_byte == serial_pkg::CH_CTRLB && !rx_perr && !rx_ferr) begin
        preq_next = 1'b1;
        st_next[serial_pkg::ST_POS_REQ] = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      waddr_reg  <= '0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
      awr_reg    <= 1'b0;
      wr_reg     <= 1'b0;
      bv_reg     <= 1'b0;
      br_reg     <= serial_pkg::RESP_OKAY;
      arr_reg    <= 1'b0;
      rv_reg     <= 1'b0;
      rd_reg     <= '0;
      rr_reg     <= serial_pkg::RESP_OKAY;
      cfg_reg    <= serial_pkg::CFG_RESET;
      boot_reg   <= 1'b1;
      nvo_reg    <= serial_pkg::CFG_RESET;
      nvs_reg    <= 1'b0;
      div_reg    <= '0;
      cur_reg    <= '0;
      cur_v_reg  <= 1'b0;
      tail_reg   <= '0;
      rxb_reg    <= '0;
      st_reg     <= '0;
      preq_reg   <= 1'b0;
    end else begin
      aw_got_reg <= aw_got_next;
      w_got_reg  <= w_got_next;
      waddr_reg  <= waddr_next;
      wdata_reg  <= wdata_next;
      wstrb_reg  <= wstrb_next;
      awr_reg    <= awr_next;
      wr_reg     <= wr_next;
      bv_reg     <= bv_next;
      br_reg     <= br_next;
      arr_reg    <= arr_next;
      rv_reg     <= rv_next;
      rd_reg     <= rd_next;
      rr_reg     <= rr_next;
      cfg_reg    <= cfg_next;
      boot_reg   <= boot_next;
      nvo_reg    <= nvo_next;
      nvs_reg    <= nvs_next;
      div_reg    <= div_next;
      cur_reg    <= cur_next;
      cur_v_reg  <= cur_v_next;
      tail_reg   <= tail_next;
      rxb_reg    <= rxb_next;
      st_reg     <= st_next;
      preq_reg   <= preq_next;
    end
  end

  assign s_axi_awready = awr_reg;
  assign s_axi_wready  = wr_reg;
  assign s_axi_bvalid  = bv_reg;
  assign s_axi_bresp   = br_reg;
  assign s_axi_arready = arr_reg;
  assign s_axi_rvalid  = rv_reg;
  assign s_axi_rdata   = rd_reg;
  assign s_axi_rresp   = rr_reg;
  assign nv_cfg_out    = nvo_reg;
  assign nv_store      = nvs_reg;
  assign pos_req       = preq_reg;

  // both directions always enabled, running at once
  serial_tx u_tx (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .bit_div  (div_reg),
    .data8    (data8),
    .par_mode (par_mode),
    .stop2    (stop2),
    .in_valid (cur_v_reg && !boot_reg),
    .in_byte  (cur_reg),
    .in_ready (tx_ready),
    .txd      (txd)
  );

  serial_rx u_rx (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .bit_div   (div_reg),
    .data8     (data8),
    .par_mode  (par_mode),
    .rxd       (rxd),
    .out_valid (rx_valid),
    .out_byte  (rx_byte),
    .out_perr  (rx_perr),
    .out_ferr  (rx_ferr)
  );
endmodule

// file: hdl/serial_pkg.sv
// Purpose: shared constants for the readout serial port
// Assumes: 32-bit register bus, one aligned word per register
// Notes:   cfg word layout is also the persistent-store word layout
package serial_pkg;
  localparam logic [7:0] OFS_CFG    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_CMD    = 8'h10;

  localparam int CFG_W      = 13;
  localparam int F_BAUD_LO  = 0;
  localparam int F_BAUD_HI  = 3;
  localparam int F_PAR_LO   = 4;
  localparam int F_PAR_HI   = 5;
  localparam int F_DATA8    = 6;
  localparam int F_STOP2    = 7;
  localparam int F_LF       = 8;
  localparam int F_TAIL_LO  = 9;
  localparam int F_TAIL_HI  = 12;
  // 9600 baud, no parity, 8 data, 1 stop, no lf, tail 0
  localparam logic [CFG_W-1:0] CFG_RESET = 13'h0044;

  localparam int ST_TX_BUSY = 0;
  localparam int ST_RX_FULL = 1;
  localparam int ST_PAR_ERR = 2;
  localparam int ST_FRM_ERR = 3;
  localparam int ST_OVERRUN = 4;
  localparam int ST_POS_REQ = 5;
  localparam int ST_W       = 6;
  localparam int CMD_TAIL   = 0;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  localparam logic [3:0] BAUD_CODES   = 4'h9;
  localparam logic [3:0] BAUD_DEFAULT = 4'h4;
  localparam int BAUD_RATE [9] = '{300, 600, 1200, 2400, 9600, 19200, 38400, 57600, 115200};
  localparam int DIV_W = 18;

  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_CTRLB = 8'h02;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // rounded clocks per bit for a baud code
  function automatic logic [DIV_W-1:0] bit_div(input logic [3:0] code, input int clk_hz);
    int rate;
    rate = BAUD_RATE[(code < BAUD_CODES) ? code : BAUD_DEFAULT];
    return DIV_W'((clk_hz + rate / 2) / rate);
  endfunction
endpackage

// file: hdl/serial_rx.sv
// Purpose: one-character serial receiver
// Assumes: rxd comes straight from a pin
// Notes:   samples each bit at its middle, checks the first stop bit
`timescale 1ns/10ps
module serial_rx (
  input  wire logic                          aclk,      // clock
  input  wire logic                          aresetn,   // sync reset, low
  input  wire logic [serial_pkg::DIV_W-1:0]  bit_div,   // clocks per bit
  input  wire logic                          data8,     // 8 data bits
  input  wire logic [1:0]                    par_mode,  // parity mode
  input  wire logic                          rxd,       // serial in
  output logic                               out_valid, // byte done, pulse
  output logic [7:0]                         out_byte,  // received byte
  output logic                               out_perr,  // parity wrong
  output logic                               out_ferr   // stop bit low
);
  typedef enum logic [2:0] {
    R_IDLE = 3'b000, R_START = 3'b001, R_DATA = 3'b010, R_PAR = 3'b011, R_STOP = 3'b100
  } rx_state_type;
  rx_state_type             state_reg, state_next;
  logic [2:0]               sync_reg;
  logic                     line_reg, line_next;
  logic [serial_pkg::DIV_W-1:0] cnt_reg, cnt_next;
  logic [2:0]               idx_reg, idx_next;
  logic [7:0]               shf_reg, shf_next;
  logic                     perr_reg, perr_next;
  logic                     valid_reg, valid_next;
  logic [7:0]               byte_reg, byte_next;
  logic                     ferr_reg, ferr_next;
  logic                     operr_reg, operr_next;
  logic                     tick;
  logic [7:0]               aligned;

  assign tick      = (cnt_reg == '0);
  assign aligned   = data8 ? shf_reg : {1'b0, shf_reg[7:1]};
  assign out_valid = valid_reg;
  assign out_byte  = byte_reg;
  assign out_perr  = operr_reg;
  assign out_ferr  = ferr_reg;

  always_comb begin
    line_next  = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : line_reg;
    state_next = state_reg;
    cnt_next   = tick ? bit_div - 1'b1 : cnt_reg - 1'b1;
    idx_next   = idx_reg;
    shf_next   = shf_reg;
    perr_next  = perr_reg;
    valid_next = 1'b0;
    byte_next  = byte_reg;
    ferr_next  = ferr_reg;
    operr_next = operr_reg;
    unique case (state_reg)
      R_IDLE: begin
        cnt_next = {1'b0, bit_div[serial_pkg::DIV_W-1:1]};
        if (!line_reg) state_next = R_START;
      end
      R_START: if (tick) begin
        idx_next   = '0;
        perr_next  = 1'b0;
        state_next = line_reg ? R_IDLE : R_DATA;
      end
      R_DATA: if (tick) begin
        shf_next = {line_reg, shf_reg[7:1]};
        idx_next = idx_reg + 1'b1;
        if (idx_reg == (data8 ? 3'd7 : 3'd6))
          state_next = (par_mode != serial_pkg::PAR_NONE) ? R_PAR : R_STOP;
      end
      R_PAR: if (tick) begin
        perr_next  = ^aligned ^ line_reg ^ (par_mode == serial_pkg::PAR_ODD);
        state_next = R_STOP;
      end
      R_STOP: if (tick) begin
        valid_next = 1'b1;
        byte_next  = aligned;
        operr_next = perr_reg;
        ferr_next  = !line_reg;
        state_next = R_IDLE;
      end
      default: state_next = R_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_reg  <= 3'b111;
      line_reg  <= 1'b1;
      state_reg <= R_IDLE;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      shf_reg   <= '0;
      perr_reg  <= 1'b0;
      valid_reg <= 1'b0;
      byte_reg  <= '0;
      ferr_reg  <= 1'b0;
      operr_reg <= 1'b0;
    end else begin
      sync_reg  <= {sync_reg[1:0], rxd};
      line_reg  <= line_next;
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      shf_reg   <= shf_next;
      perr_reg  <= perr_next;
      valid_reg <= valid_next;
      byte_reg  <= byte_next;
      ferr_reg  <= ferr_next;
      operr_reg <= operr_next;
    end
  end
endmodule

// file: hdl/serial_tx.sv
// Purpose: one-character serial transmitter
// Assumes: bit_div and format stay stable while a frame is sent
// Notes:   idle line is high
`timescale 1ns/10ps
module serial_tx (
  input  wire logic                          aclk,      // clock
  input  wire logic                          aresetn,   // sync reset, low
  input  wire logic [serial_pkg::DIV_W-1:0]  bit_div,   // clocks per bit
  input  wire logic                          data8,     // 8 data bits
  input  wire logic [1:0]                    par_mode,  // parity mode
  input  wire logic                          stop2,     // two stop bits
  input  wire logic                          in_valid,  // byte offered
  input  wire logic [7:0]                    in_byte,   // byte to send
  output logic                               in_ready,  // idle, takes byte
  output logic                               txd        // serial out
);
  typedef enum logic [2:0] {
    T_IDLE = 3'b000, T_START = 3'b001, T_DATA = 3'b010, T_PAR = 3'b011, T_STOP = 3'b100
  } tx_state_type;
  tx_state_type             state_reg, state_next;
  logic [serial_pkg::DIV_W-1:0] cnt_reg, cnt_next;
  logic [2:0]               idx_reg, idx_next;
  logic [7:0]               shf_reg, shf_next;
  logic                     par_reg, par_next;
  logic                     stopn_reg, stopn_next;
  logic                     txd_reg, txd_next;
  logic                     tick;

  assign tick     = (cnt_reg == '0);
  assign in_ready = (state_reg == T_IDLE);
  assign txd      = txd_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = tick ? bit_div - 1'b1 : cnt_reg - 1'b1;
    idx_next   = idx_reg;
    shf_next   = shf_reg;
    par_next   = par_reg;
    stopn_next = stopn_reg;
    txd_next   = txd_reg;
    unique case (state_reg)
      T_IDLE: begin
        cnt_next = bit_div - 1'b1;
        txd_next = 1'b1;
        if (in_valid) begin
          shf_next   = in_byte;
          par_next   = ^(data8 ? in_byte : {1'b0, in_byte[6:0]}) ^ (par_mode == serial_pkg::PAR_ODD);
          stopn_next = stop2;
          txd_next   = 1'b0;
          state_next = T_START;
        end
      end
      T_START: if (tick) begin
        txd_next   = shf_reg[0];
        idx_next   = '0;
        state_next = T_DATA;
      end
      T_DATA: if (tick) begin
        if (idx_reg == (data8 ? 3'd7 : 3'd6)) begin
          if (par_mode != serial_pkg::PAR_NONE) begin
            txd_next   = par_reg;
            state_next = T_PAR;
          end else begin
            txd_next   = 1'b1;
            state_next = T_STOP;
          end
        end else begin
          idx_next = idx_reg + 1'b1;
          shf_next = {1'b0, shf_reg[7:1]};
          txd_next = shf_reg[1];
        end
      end
      T_PAR: if (tick) begin
        txd_next   = 1'b1;
        state_next = T_STOP;
      end
      T_STOP: if (tick) begin
        if (stopn_reg) stopn_next = 1'b0;
        else state_next = T_IDLE;
      end
      default: state_next = T_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= T_IDLE;
      cnt_reg   <= '0;
      idx_reg   <= '0;
      shf_reg   <= '0;
      par_reg   <= 1'b0;
      stopn_reg <= 1'b0;
      txd_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      idx_reg   <= idx_next;
      shf_reg   <= shf_next;
      par_reg   <= par_next;
      stopn_reg <= stopn_next;
      txd_reg   <= txd_next;
    end
  end
endmodule

// file: testbench/echo_terminal.sv
// Purpose: far terminal that echoes each character back
// Assumes: same line settings at both ends
// Notes:   one clock of wire delay
`timescale 1ns/10ps
module echo_terminal (
  input  wire logic aclk, // clk
  input  wire logic txd,  // from port
  output logic      rxd = 1'b1 // to port
);
  always @(posedge aclk) rxd <= txd;
endmodule

// file: testbench/readout_serial_port_tb_top.sv
// Purpose: register level test of readout_serial_port
// Assumes: echo terminal on the line
// Notes:   CLK_HZ shortened to 8 clocks a bit at 115200
`timescale 1ns/10ps
module readout_serial_port_tb_top;
  logic        aclk = 0, aresetn = 0, rxd, txd, awready, wready, bvalid, arready, rvalid;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d, c;
  logic [1:0]  bresp, rresp, r;
  logic [12:0] nvo;
  logic [3:0]  wstrb = 4'hF;
  logic        nvs, preq;
  int          error_cnt = 0, n_compared = 0, p, n_pos = 0, n_save = 0;
  always #10 aclk = ~aclk;
  readout_serial_port #(.CLK_HZ(921600)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rxd(rxd), .txd(txd), .nv_cfg_in(13'h0048), .nv_cfg_out(nvo), .nv_store(nvs),
    .pos_req(preq));
  echo_terminal far (.aclk(aclk), .txd(txd), .rxd(rxd));
  always @(posedge aclk) begin
    if (preq === 1'b1) n_pos <= n_pos + 1;
    if (nvs === 1'b1) n_save <= n_save + 1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    rd(a);
    n_compared++;
    if (d !== e || r !== er) begin
      error_cnt++;
      $display("BAD %0t addr %h got %h resp %h", $time, a, d, r);
    end
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // poll until sender idle and a byte is held
  task automatic settle;
    int i;
    i = 0;
    do begin
      rd(8'h04);
      i++;
    end while (d[1:0] !== 2'h2 && i < 1000);
  endtask
  task automatic final_report;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    chk(8'h00, 32'h0000_0048);
    chk(8'h04, 32'h0000_0000);
    wr(8'h08, 32'h0000_0002);
    settle();
    chk(8'h04, 32'h0000_0022);
    cmp(32'(n_pos), 32'h0000_0001);
    chk(8'h0C, 32'h0000_0002);
    wr(8'h04, 32'h0000_003E);
    chk(8'h04, 32'h0000_0000);
    for (p = 0; p < 3; p++) begin
      c = 32'(8 - p) | 32'(p << 4) | (p == 1 ? 32'h0000_0080 : 32'h0000_0040);
      wr(8'h00, c);
      chk(8'h00, c);
      cmp(32'(nvo), c);
      wr(8'h08, 32'h0000_00C5);
      settle();
      chk(8'h04, 32'h0000_0002);
      chk(8'h0C, p == 1 ? 32'h0000_0045 : 32'h0000_00C5);
    end
    wstrb <= 4'h2;
    wr(8'h00, 32'h0000_05FF);
    wstrb <= 4'hF;
    chk(8'h00, 32'h0000_0566);
    cmp(32'(nvo), 32'h0000_0566);
    wr(8'h10, 32'h0000_0001);
    settle();
    chk(8'h04, 32'h0000_0012);
    chk(8'h0C, 32'h0000_000A);
    chk(8'h14, 32'h0000_0000, 2'h3);
    cmp(32'(n_save), 32'h0000_0004);
    final_report();
  end
  initial begin
    repeat (50000) @(posedge aclk);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    final_report();
  end
endmodule

// file: testbench/serial_port_checker_asserts.sv
// Purpose: port checks for readout_serial_port
// Assumes: CLK_HZ=921600, so the fastest code gives 8 clocks a bit
// Notes:   bound to the top module
`timescale 1ns/10ps
module serial_port_checker (
  input wire logic       aclk,          // clk
  input wire logic       aresetn,       // rst
  input wire logic       s_axi_awvalid, // aw
  input wire logic       s_axi_awready, // aw
  input wire logic       s_axi_wvalid,  // w
  input wire logic       s_axi_wready,  // w
  input wire logic [1:0] s_axi_bresp,   // b
  input wire logic       s_axi_bvalid,  // b
  input wire logic       s_axi_bready,  // b
  input wire logic       s_axi_arvalid, // ar
  input wire logic       s_axi_arready, // ar
  input wire logic       s_axi_rvalid,  // r
  input wire logic       s_axi_rready,  // r
  input wire logic       txd,           // line out
  input wire logic       nv_store,      // save
  input wire logic       pos_req        // ctrl-b
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence resp_late;
    !s_axi_bvalid ##1 s_axi_bvalid;
  endsequence
  a_write_answer: assert property (both_taken |=> resp_late)
    else $error("write answer timing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h3)
    else $error("bad write code");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer timing");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  a_store_pulse: assert property (nv_store |=> !nv_store)
    else $error("save strobe too long");
  a_pos_pulse: assert property (pos_req |=> !pos_req)
    else $error("ctrl-b pulse too long");
  a_low_min: assert property ($fell(txd) |-> !txd [*8])
    else $error("low bit too short");
  a_reset_idle: assert property ($rose(aresetn) |-> txd && !s_axi_bvalid)
    else $error("not idle after reset");
endmodule
bind readout_serial_port serial_port_checker chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .txd(txd), .nv_store(nv_store), .pos_req(pos_req));
